/* File: rtl/ptu_top.v */
// Local design decisions: the register offsets and the APB interface to the registers.
`include "ptu_consts.vh"
module ptu_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,         // freezes all state while low
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [3:0]  ext_count_clk,  // external count clock pins
  input  wire [3:0]  timer_io_in0,   // channel 0 pins a..d
  input  wire [1:0]  timer_io_in1,
  input  wire [1:0]  timer_io_in2,
  output wire [3:0]  timer_io_out0,
  output wire [3:0]  timer_io_oe0,
  output wire [1:0]  timer_io_out1,
  output wire [1:0]  timer_io_oe1,
  output wire [1:0]  timer_io_out2,
  output wire [1:0]  timer_io_oe2,
  output wire [2:0]  overflow_irq,   // per channel request
  output wire [2:0]  match_irq       // per channel request
);
  reg  [2:0]  run_q;                 // channel run bits
  reg  [2:0]  sync_q;                // sync select bits
  reg         stop_q;                // module stop bit
  reg  [7:0]  ctrl_q [0:2];          // control registers
  reg  [7:0]  mode_q [0:2];          // mode registers
  reg  [15:0] io_q   [0:2];          // io control, 4 bits per register
  reg  [7:0]  ier_q  [0:2];          // irq enables
  wire [15:0] cnt    [0:2];
  wire [63:0] grf    [0:2];
  wire [7:0]  flg    [0:2];
  wire [3:0]  pout   [0:2];
  wire [3:0]  poe    [0:2];
  wire [2:0]  clr_evt;
  wire [3:0]  pin_in [0:2];
  wire        wr_en  = psel & penable & pwrite;    // single-cycle access
  wire        rd_en  = psel & penable & ~pwrite;
  // byte offset inside a channel block
  wire        in_ch  = (paddr >= `PTU_CH_BASE) && (paddr < `PTU_CH_BASE + 3 * `PTU_CH_STRIDE);
  wire [11:0] ch_rel = paddr - `PTU_CH_BASE;
  wire [1:0]  ch     = ch_rel[7:6];
  wire [11:0] reg_of = {6'h00, ch_rel[5:0]};
  // module stop gates the channels, bus writes to counter, general and flag registers included
  wire        en     = clk_en & ~stop_q;
  assign pin_in[0] = timer_io_in0;
  assign pin_in[1] = {2'b00, timer_io_in1};
  assign pin_in[2] = {2'b00, timer_io_in2};
  // sync clear: any synchronous channel's own clear event
  wire sync_evt = |(clr_evt & sync_q);
  // byte lanes: 8-bit registers honour the lane 0 strobe only
  function [7:0] lane8;
    input [7:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      lane8 = s[0] ? d[7:0] : old;
    end
  endfunction
  // common registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q  <= 3'b000;
      sync_q <= 3'b000;
      stop_q <= 1'b1;
    end else if (clk_en && wr_en) begin
      if (paddr == `PTU_OFF_RUN && pstrb[0])
        run_q <= pwdata[2:0];
      if (paddr == `PTU_OFF_SYNC && pstrb[0])
        sync_q <= pwdata[2:0];
      if (paddr == `PTU_OFF_STOP && pstrb[0])
        stop_q <= pwdata[0];
    end
  end
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_ch
      wire sel   = in_ch && (ch == c) && wr_en && clk_en;
      // counter write: own, or any sync peer when this one is sync
      wire own_w = sel && (reg_of == `PTU_CH_CNT) && (pstrb[1:0] == 2'b11);
      wire any_w = in_ch && wr_en && clk_en && (reg_of == `PTU_CH_CNT) &&
                   (pstrb[1:0] == 2'b11) && sync_q[ch] && sync_q[c];
      wire [3:0] grw;
      assign grw[0] = sel && (reg_of == `PTU_CH_GR0) && (pstrb[1:0] == 2'b11);
      assign grw[1] = sel && (reg_of == `PTU_CH_GR1) && (pstrb[1:0] == 2'b11);
      assign grw[2] = sel && (reg_of == `PTU_CH_GR2) && (pstrb[1:0] == 2'b11) && (c == 0);
      assign grw[3] = sel && (reg_of == `PTU_CH_GR3) && (pstrb[1:0] == 2'b11) && (c == 0);
      // flag write: zero clears, one leaves unchanged
      wire [7:0] fclr = (sel && reg_of == `PTU_CH_FLAG && pstrb[0]) ?
                        ~pwdata[7:0] : 8'h00;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_q[c] <= 8'h00;
          mode_q[c] <= 8'h00;
          io_q[c]   <= 16'h0000;
          ier_q[c]  <= 8'h00;
        end else if (sel) begin
          if (reg_of == `PTU_CH_CTRL)
            ctrl_q[c] <= lane8(ctrl_q[c], pwdata, pstrb);
          if (reg_of == `PTU_CH_MODE)
            mode_q[c] <= lane8(mode_q[c], pwdata, pstrb);
          if (reg_of == `PTU_CH_IER)
            ier_q[c]  <= lane8(ier_q[c], pwdata, pstrb);
          if (reg_of == `PTU_CH_IO) begin
            if (pstrb[0])
              io_q[c][7:0]  <= pwdata[7:0];
            if (pstrb[1])
              io_q[c][15:8] <= pwdata[15:8];
          end
        end
      end
      ptu_chan #(
        .NGR   ((c == 0) ? 4 : 2),
        .BUFOK ((c == 0) ? 1 : 0),
        .PHOK  ((c == 0) ? 0 : 1)
      ) u_chan (
        .pclk      (pclk),
        .presetn   (presetn),
        .en        (en),
        .run       (run_q[c]),
        .ctrl      (ctrl_q[c]),
        .mode      (mode_q[c]),
        .io_cfg    (io_q[c]),
        .ext_clk   ((c == 2) ? {ext_count_clk[1:0], ext_count_clk[3:2]} : ext_count_clk),
        .pin_in    (pin_in[c]),
        .cnt_wr    (own_w | any_w),
        .cnt_wdata (pwdata[15:0]),
        .sync_clr  (sync_q[c] & sync_evt),
        .gr_wr     (grw),
        .wdata     (pwdata[15:0]),
        .flag_clr  (fclr),
        .clr_evt   (clr_evt[c]),
        .cnt_q     (cnt[c]),
        .gr_flat   (grf[c]),
        .flags     (flg[c]),
        .pin_out_q (pout[c]),
        .pin_oe    (poe[c])
      );
      // requests follow flags gated by enables
      assign overflow_irq[c] = flg[c][`PTU_FLG_OVF] & ier_q[c][`PTU_FLG_OVF];
      assign match_irq[c]    = |(flg[c][3:0] & ier_q[c][3:0]);
    end
  endgenerate
  assign timer_io_out0 = pout[0];
  assign timer_io_oe0  = poe[0];
  assign timer_io_out1 = pout[1][1:0];
  assign timer_io_oe1  = poe[1][1:0];
  assign timer_io_out2 = pout[2][1:0];
  assign timer_io_oe2  = poe[2][1:0];
  // read mux
  reg [31:0] rd;
  reg        hit;
  always @* begin
    rd  = 32'h00000000;
    hit = 1'b1;
    if (paddr == `PTU_OFF_RUN)
      rd = {29'h0, run_q};
    else if (paddr == `PTU_OFF_SYNC)
      rd = {29'h0, sync_q};
    else if (paddr == `PTU_OFF_STOP)
      rd = {31'h0, stop_q};
    else if (in_ch && ch != 2'd3) begin
      case (reg_of)
        `PTU_CH_CTRL: rd = {24'h0, ctrl_q[ch]};
        `PTU_CH_MODE: rd = {24'h0, mode_q[ch]};
        `PTU_CH_IO:   rd = {16'h0, io_q[ch]};
        `PTU_CH_IER:  rd = {24'h0, ier_q[ch]};
        `PTU_CH_FLAG: rd = {24'h0, flg[ch]};
        `PTU_CH_CNT:  rd = {16'h0, cnt[ch]};
        `PTU_CH_GR0:  rd = {16'h0, grf[ch][15:0]};
        `PTU_CH_GR1:  rd = {16'h0, grf[ch][31:16]};
        `PTU_CH_GR2:  rd = {16'h0, grf[ch][47:32]};
        `PTU_CH_GR3:  rd = {16'h0, grf[ch][63:48]};
        default:      hit = 1'b0;
      endcase
    end else
      hit = 1'b0;
  end
  assign prdata  = rd_en ? rd : 32'h00000000;
  assign pready  = 1'b1;                             // zero wait states
  assign pslverr = psel & penable & ~hit;
endmodule

/* File: rtl/ptu_consts.vh */
`ifndef PTU_CONSTS_VH
`define PTU_CONSTS_VH
// register byte offsets (one aligned apb word each)
`define PTU_OFF_RUN      12'h000
`define PTU_OFF_SYNC     12'h004
`define PTU_OFF_STOP     12'h008
// per-channel block: base + ch * stride
`define PTU_CH_BASE      12'h040
`define PTU_CH_STRIDE    12'h040
`define PTU_CH_CTRL      12'h000
`define PTU_CH_MODE      12'h004
`define PTU_CH_IO        12'h008
`define PTU_CH_IER       12'h00c
`define PTU_CH_FLAG      12'h010
`define PTU_CH_CNT       12'h014
`define PTU_CH_GR0       12'h018
`define PTU_CH_GR1       12'h01c
`define PTU_CH_GR2       12'h020
`define PTU_CH_GR3       12'h024
// reset values and the counter maximum
`define PTU_GR_RST       16'hffff
`define PTU_CNT_RST      16'h0000
`define PTU_CNT_MAX      16'hffff
// control register fields
`define PTU_CTRL_CLR_LSB 5
`define PTU_CTRL_EDG_LSB 3
`define PTU_CTRL_PSC_LSB 0
// clear source codes
`define PTU_CLR_NONE     3'd0
`define PTU_CLR_GR0      3'd1
`define PTU_CLR_GR1      3'd2
`define PTU_CLR_SYNC     3'd3
`define PTU_CLR_GR2      3'd5
`define PTU_CLR_GR3      3'd6
// mode register fields
`define PTU_MODE_PHASE   3'd4
`define PTU_MODE_BFA     4
`define PTU_MODE_BFB     5
// flag register bit positions and reset value
`define PTU_FLG_OVF      4
`define PTU_FLG_UDF      5
`define PTU_FLG_DIR      7
`define PTU_FLG_RST      8'hc0
`endif

/* File: rtl/ptu_chan.v */
`include "ptu_consts.vh"
// one timer channel: counter, NGR general registers (up to four), io pins, flags
module ptu_chan #(
  parameter NGR   = 4,   // general registers in this channel
  parameter BUFOK = 0,   // buffer operation available
  parameter PHOK  = 0    // phase counting available
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        en,           // clock enable and not stopped
  input  wire        run,          // channel run bit
  input  wire [7:0]  ctrl,         // channel control register
  input  wire [7:0]  mode,         // channel mode register
  input  wire [15:0] io_cfg,       // four 4-bit io settings
  input  wire [3:0]  ext_clk,      // external count clock pins (sync)
  input  wire [3:0]  pin_in,       // timer io pin inputs (sync)
  input  wire        cnt_wr,       // counter preset strobe
  input  wire [15:0] cnt_wdata,    // preset value
  input  wire        sync_clr,     // synchronous clear from peers
  input  wire [3:0]  gr_wr,        // general register write strobes
  input  wire [15:0] wdata,        // bus write data
  input  wire [7:0]  flag_clr,     // flag bits written with zero
  output wire        clr_evt,      // own clearing event for peers
  output reg  [15:0] cnt_q,        // channel counter
  output wire [63:0] gr_flat,      // general registers
  output wire [7:0]  flags,        // flag register image
  output reg  [3:0]  pin_out_q,    // compare outputs
  output wire [3:0]  pin_oe        // compare output enables
);
  reg  [15:0] gr_q [0:3];           // general registers
  reg  [7:0]  flg_q;                // sticky flags
  reg  [3:0]  pin_d1_q;             // previous pin sample
  reg  [3:0]  ext_d1_q;             // previous external clock sample
  reg  [3:0]  pscnt_q;              // prescaler
  reg         dir_q;                // last count direction, 1 = up
  reg         run_d1_q;             // previous run state
  wire [2:0]  clr_sel = ctrl[7:5];
  wire [1:0]  edg     = ctrl[4:3];
  wire [2:0]  psc     = ctrl[2:0];
  wire        phase   = (PHOK != 0) && (mode[2:0] == `PTU_MODE_PHASE);
  wire [3:0]  match, capt;
  reg         tick, up, down;
  // count clock select: prescaled pclk or an external pin edge
  always @* begin
    tick = 1'b0;
    up   = 1'b0;
    down = 1'b0;
    if (phase) begin
      // two-phase decode, a leads b counts up
      if (ext_clk[0] != ext_d1_q[0]) begin
        up   = (ext_clk[0] != ext_clk[1]);
        down = ~up;
      end else if (ext_clk[1] != ext_d1_q[1]) begin
        up   = (ext_clk[0] == ext_clk[1]);
        down = ~up;
      end
      up   = up & run;
      down = down & run;
    end else begin
      case (psc)
        3'd0:    tick = 1'b1;
        3'd1:    tick = (pscnt_q[1:0] == 2'b11);
        3'd2:    tick = (pscnt_q == 4'hf);
        3'd3:    tick = (psc == 3'd3) && (pscnt_q[2:0] == 3'b111);
        3'd4:    tick = ext_clk[0] & ~ext_d1_q[0];
        3'd5:    tick = ext_clk[1] & ~ext_d1_q[1];
        default: tick = ext_clk[2] & ~ext_d1_q[2];
      endcase
      up = tick & run;
    end
  end
  // per-register compare and capture detection
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_gr
      wire cap_mode = io_cfg[4*g+3];   // 1 = capture, else compare
      wire rise     = pin_in[g] & ~pin_d1_q[g];
      wire fall     = ~pin_in[g] & pin_d1_q[g];
      assign match[g] = (g < NGR) && !cap_mode && run && (up | down) && (cnt_q == gr_q[g]);
      assign capt[g]  = (g < NGR) && cap_mode &&
                        ((io_cfg[4*g+1:4*g] == 2'd0 && rise) ||
                         (io_cfg[4*g+1:4*g] == 2'd1 && fall) ||
                         (io_cfg[4*g+1] && (rise | fall)));
      assign gr_flat[16*g+15:16*g] = gr_q[g];
      assign pin_oe[g] = (g < NGR) && !cap_mode && (io_cfg[4*g+1:4*g] != 2'd0);
    end
  endgenerate
  // clear source decode
  reg own_clr;
  always @* begin
    case (clr_sel)
      `PTU_CLR_GR0: own_clr = match[0] | capt[0];
      `PTU_CLR_GR1: own_clr = match[1] | capt[1];
      `PTU_CLR_GR2: own_clr = match[2] | capt[2];
      `PTU_CLR_GR3: own_clr = match[3] | capt[3];
      default:      own_clr = 1'b0;
    endcase
  end
  assign clr_evt = own_clr;
  wire do_clr = own_clr | ((clr_sel == `PTU_CLR_SYNC) && sync_clr);
  wire bfa = (BUFOK != 0) && mode[`PTU_MODE_BFA];
  wire bfb = (BUFOK != 0) && mode[`PTU_MODE_BFB];
  wire [3:0] bufd = {bfb, bfa, 2'b00};
  integer i;
  // counter, registers, flags and pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= `PTU_CNT_RST;
      flg_q     <= `PTU_FLG_RST;
      pin_d1_q  <= 4'h0;
      ext_d1_q  <= 4'h0;
      pscnt_q   <= 4'h0;
      dir_q     <= 1'b1;
      run_d1_q  <= 1'b0;
      pin_out_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        gr_q[i] <= `PTU_GR_RST;
    end else if (en) begin
      pin_d1_q <= pin_in;
      ext_d1_q <= ext_clk;
      run_d1_q <= run;
      pscnt_q  <= run ? pscnt_q + 4'h1 : 4'h0;
      // counter: preset beats clear beats count
      if (cnt_wr)
        cnt_q <= cnt_wdata;
      else if (do_clr)
        cnt_q <= `PTU_CNT_RST;
      else if (up)
        cnt_q <= cnt_q + 16'h0001;
      else if (down)
        cnt_q <= cnt_q - 16'h0001;
      if (up | down)
        dir_q <= up;
      // flags: software clear first, hardware set wins
      flg_q <= (flg_q & ~flag_clr) | `PTU_FLG_RST;
      if (!do_clr && up && cnt_q == `PTU_CNT_MAX)
        flg_q[`PTU_FLG_OVF] <= 1'b1;
      if (!do_clr && down && cnt_q == `PTU_CNT_RST)
        flg_q[`PTU_FLG_UDF] <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        if (match[i] | capt[i])
          flg_q[i] <= 1'b1;
        if (gr_wr[i])
          gr_q[i] <= wdata;
        if (i < 2 && capt[i]) begin
          gr_q[i] <= cnt_q;
          if (bufd[i+2])
            gr_q[i+2] <= gr_q[i];
        end else if (i < 2 && match[i] && bufd[i+2])
          gr_q[i] <= gr_q[i+2];
        else if (i >= 2 && capt[i] && !bufd[i])
          gr_q[i] <= cnt_q;
        // pin level: 1=low 2=high 3=toggle; same level leaves pin
        if (match[i]) begin
          case (io_cfg[4*i+1 +: 1] ? {1'b1, io_cfg[4*i]} : {1'b0, io_cfg[4*i]})
            2'b01:   pin_out_q[i] <= 1'b0;
            2'b10:   pin_out_q[i] <= 1'b1;
            2'b11:   pin_out_q[i] <= ~pin_out_q[i];
            default: pin_out_q[i] <= pin_out_q[i];
          endcase
        end
        // stopping the counter holds the pin level
        if (!run && gr_wr[i])
          pin_out_q[i] <= pin_out_q[i];
      end
    end
  end
  assign flags = {phase ? dir_q : 1'b1, flg_q[6:0]};
endmodule

/* File: test/ptu_top_props.sv */
`include "ptu_consts.vh"
// port-level checker for the timer unit
module ptu_top_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  timer_io_out0,
  input wire logic [1:0]  timer_io_out1,
  input wire logic [1:0]  timer_io_out2,
  input wire logic [2:0]  overflow_irq,
  input wire logic [2:0]  match_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] run_q;   // shadow of the run bits
  logic       stop_q;  // shadow of the module stop bit
  wire        wr_go = psel && penable && pwrite && clk_en;  // write taken this edge
  wire  [7:0] pins  = {timer_io_out2, timer_io_out1, timer_io_out0};
  // shadow copies, so stop conditions need no look inside the design
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q  <= 3'h0;
      stop_q <= 1'b1;
    end else if (wr_go && pstrb[0]) begin
      if (paddr == `PTU_OFF_RUN) run_q <= pwdata[2:0];
      if (paddr == `PTU_OFF_STOP) stop_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // three quiet edges so a late match from a write cannot be mistaken
  sequence s_no_writes;
    !$past(wr_go) && !$past(wr_go, 2) && !$past(wr_go, 3);
  endsequence
  a_ready_at_access: assert property (s_setup ##1 s_access |-> pready)
    else $error("access phase without ready");
  a_slverr_in_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_ovf_irq_fall: assert property ((~overflow_irq & $past(overflow_irq)) != 3'h0 |-> $past(wr_go))
    else $error("overflow request dropped without a write");
  a_match_irq_fall: assert property ((~match_irq & $past(match_irq)) != 3'h0 |-> $past(wr_go))
    else $error("match request dropped without a write");
  a_freeze_pins: assert property (!$past(clk_en) |-> $stable(pins))
    else $error("compare pins moved while frozen");
  a_freeze_irqs: assert property (!$past(clk_en) |-> $stable(match_irq) && $stable(overflow_irq))
    else $error("requests moved while frozen");
  a_stopped_pins_hold: assert property (((run_q == 3'h0) and s_no_writes) |-> $stable(pins))
    else $error("compare pins moved with all channels stopped");
  a_module_stop_hold: assert property ((stop_q and s_no_writes) |-> $stable(pins))
    else $error("compare pins moved in module stop");
endmodule
bind ptu_top ptu_top_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .timer_io_out0(timer_io_out0),
  .timer_io_out1(timer_io_out1), .timer_io_out2(timer_io_out2),
  .overflow_irq(overflow_irq), .match_irq(match_irq));

/* File: test/ptu_pin_model.sv */
// far-side pin source: capture inputs and external clocks, toggled on request
module ptu_pin_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,  // toggle the selected pin at this edge
  input  wire logic [3:0]  sel,   // pin index
  output logic      [11:0] pins   // in0 3:0, in1 5:4, in2 7:6, ext 11:8
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins change only on the clock, like a synchronous neighbour
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) pins <= 12'h000;
    else if (fire) pins[sel] <= ~pins[sel];
  end
endmodule

/* File: test/testbench.sv */
`include "ptu_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err_q, fire;
  logic [11:0] paddr, pins;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0]  pstrb, sel, out0, oe0, out_keep;
  logic [1:0]  out1, oe1, out2, oe2;
  logic [2:0]  ovf_irq, mt_irq;
  logic [15:0] per, val;
  int          n_fail, total_checks;
  wire  [5:0]  irq_all = {mt_irq, ovf_irq};
  logic [11:0] ra [6] = '{`PTU_OFF_RUN, `PTU_OFF_SYNC, `PTU_OFF_STOP, 12'h050, 12'h054, 12'h0dc};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h1, 32'hc0, 32'h0, 32'hffff};
  ptu_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_clk(pins[11:8]), .timer_io_in0(pins[3:0]),
    .timer_io_in1(pins[5:4]), .timer_io_in2(pins[7:6]), .timer_io_out0(out0),
    .timer_io_oe0(oe0), .timer_io_out1(out1), .timer_io_oe1(oe1), .timer_io_out2(out2),
    .timer_io_oe2(oe2), .overflow_irq(ovf_irq), .match_irq(mt_irq));
  ptu_pin_model u_pins (.pclk(pclk), .presetn(presetn), .fire(fire), .sel(sel), .pins(pins));
  // channel register address
  function automatic logic [11:0] ca(input logic [1:0] c, input logic [11:0] o);
    return `PTU_CH_BASE + {4'h0, c, 6'h00} + o;
  endfunction
  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for one request line
  task automatic wait_irq(input int b);
    int k;
    k = 0;
    // let the edge that took a flag clear pass before looking
    do begin
      @(posedge pclk);
      k++;
    end while (irq_all[b] !== 1'b1 && k < 3000);
    chk("irq", 32'h1, {31'h0, irq_all[b]});
  endtask
  task automatic toggle_pin(input logic [3:0] p);
    @(posedge pclk);
    fire <= 1'b1;
    sel <= p;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard, far beyond the expected run
  initial begin
    repeat (50000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, fire} = 5'h0;
    {paddr, pwdata, pstrb, sel} = 0;
    clk_en = 1'b1;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(2771));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0, 4'hf);
      chk("reset value", rv[i], rd_q & 32'hffff);
    end
    apb(1'b0, 12'hffc, 32'h0, 4'hf);
    chk("unmapped error", 32'h1, {31'h0, err_q});
    apb(1'b1, `PTU_OFF_RUN, 32'h1, 4'h1);
    apb(1'b0, ca(0, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("stopped module count", 32'h0, rd_q & 32'hffff);
    apb(1'b1, `PTU_OFF_RUN, 32'h0, 4'h1);
    apb(1'b1, `PTU_OFF_STOP, 32'h0, 4'h1);
    $display("test reset done");
    // channel 0: periodic count, buffered compare, toggle/high/low pins
    per = 16'd40 + 16'($urandom % 40);
    apb(1'b1, ca(0, `PTU_CH_CTRL), 32'h20, 4'h1);
    apb(1'b1, ca(0, `PTU_CH_MODE), 32'h10, 4'h1);
    apb(1'b1, ca(0, `PTU_CH_IO), 32'h1023, 4'h3);
    apb(1'b1, ca(0, `PTU_CH_GR0), {16'h0, per}, 4'hf);
    apb(1'b1, ca(0, `PTU_CH_GR1), 32'h5, 4'hf);
    apb(1'b1, ca(0, `PTU_CH_GR2), {16'h0, per + 16'd10}, 4'hf);
    apb(1'b1, ca(0, `PTU_CH_GR3), 32'h7, 4'hf);
    apb(1'b1, ca(0, `PTU_CH_IER), 32'h1, 4'h1);
    apb(1'b1, `PTU_OFF_RUN, 32'h1, 4'h1);
    wait_irq(3);
    apb(1'b0, ca(0, `PTU_CH_FLAG), 32'h0, 4'hf);
    chk("match flags", 32'hb, rd_q & 32'hb);
    chk("pins first", 32'h3, {28'h0, out0 & 4'hb});
    chk("output enables", 32'hb, {28'h0, oe0});
    apb(1'b0, ca(0, `PTU_CH_GR0), 32'h0, 4'hf);
    chk("buffered period", {16'h0, per + 16'd10}, rd_q & 32'hffff);
    apb(1'b1, ca(0, `PTU_CH_FLAG), 32'h0, 4'h1);
    wait_irq(3);
    chk("pins second", 32'h2, {28'h0, out0 & 4'hb});
    apb(1'b1, `PTU_OFF_RUN, 32'h0, 4'h1);
    out_keep = out0;
    apb(1'b0, ca(0, `PTU_CH_CNT), 32'h0, 4'hf);
    val = rd_q[15:0];
    repeat (50) @(posedge pclk);
    apb(1'b0, ca(0, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("stopped count", {16'h0, val}, rd_q & 32'hffff);
    chk("held pins", {28'h0, out_keep}, {28'h0, out0});
    $display("test compare done");
    // channel 1: free run through the wrap
    apb(1'b1, ca(1, `PTU_CH_IER), 32'h10, 4'h1);
    apb(1'b1, ca(1, `PTU_CH_CNT), 32'hfff0, 4'hf);
    apb(1'b1, `PTU_OFF_RUN, 32'h2, 4'h1);
    wait_irq(1);
    apb(1'b0, ca(1, `PTU_CH_FLAG), 32'h0, 4'hf);
    chk("overflow flag", 32'h10, rd_q & 32'h10);
    apb(1'b0, ca(1, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("count after wrap", 32'h1, {31'h0, rd_q[15:0] < 16'd64});
    clk_en <= 1'b0;
    apb(1'b0, ca(1, `PTU_CH_CNT), 32'h0, 4'hf);
    val = rd_q[15:0];
    repeat (20) @(posedge pclk);
    apb(1'b0, ca(1, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("frozen count", {16'h0, val}, rd_q & 32'hffff);
    clk_en <= 1'b1;
    apb(1'b1, `PTU_OFF_RUN, 32'h0, 4'h1);
    $display("test overflow done");
    // channels 1 and 2 in step: preset and clear together
    apb(1'b1, `PTU_OFF_SYNC, 32'h6, 4'h1);
    val = 16'($urandom);
    apb(1'b1, ca(1, `PTU_CH_CNT), {16'h0, val}, 4'hf);
    apb(1'b0, ca(2, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("sync preset", {16'h0, val}, rd_q & 32'hffff);
    apb(1'b1, ca(2, `PTU_CH_CTRL), 32'h60, 4'h1);
    apb(1'b1, ca(1, `PTU_CH_CTRL), 32'h20, 4'h1);
    apb(1'b1, ca(1, `PTU_CH_GR0), 32'd50, 4'hf);
    apb(1'b1, ca(1, `PTU_CH_CNT), 32'h0, 4'hf);
    apb(1'b1, ca(1, `PTU_CH_FLAG), 32'h0, 4'h1);
    apb(1'b1, ca(1, `PTU_CH_IER), 32'h1, 4'h1);
    apb(1'b1, `PTU_OFF_RUN, 32'h6, 4'h1);
    wait_irq(4);
    apb(1'b1, `PTU_OFF_RUN, 32'h0, 4'h1);
    apb(1'b0, ca(2, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("sync clear", 32'h1, {31'h0, rd_q[15:0] < 16'd50});
    $display("test sync done");
    // channel 2: capture on rising for gr0, falling for gr1
    apb(1'b1, `PTU_OFF_SYNC, 32'h0, 4'h1);
    val = 16'($urandom);
    apb(1'b1, ca(2, `PTU_CH_CNT), {16'h0, val}, 4'hf);
    apb(1'b1, ca(2, `PTU_CH_IO), 32'h98, 4'h3);
    apb(1'b1, ca(2, `PTU_CH_FLAG), 32'h0, 4'h1);
    toggle_pin(4'd6);
    toggle_pin(4'd7);
    apb(1'b0, ca(2, `PTU_CH_FLAG), 32'h0, 4'hf);
    chk("rise captures", 32'h1, rd_q & 32'h3);
    apb(1'b0, ca(2, `PTU_CH_GR0), 32'h0, 4'hf);
    chk("captured gr0", {16'h0, val}, rd_q & 32'hffff);
    toggle_pin(4'd7);
    apb(1'b0, ca(2, `PTU_CH_GR1), 32'h0, 4'hf);
    chk("captured gr1", {16'h0, val}, rd_q & 32'hffff);
    // channel 0: buffered capture into gr0, which also clears the counter
    apb(1'b1, ca(0, `PTU_CH_IO), 32'h08, 4'h1);
    apb(1'b1, ca(0, `PTU_CH_GR0), 32'h1234, 4'hf);
    apb(1'b1, ca(0, `PTU_CH_CNT), {16'h0, val | 16'h1}, 4'hf);
    toggle_pin(4'd0);
    apb(1'b0, ca(0, `PTU_CH_GR2), 32'h0, 4'hf);
    chk("buffered capture", 32'h1234, rd_q & 32'hffff);
    apb(1'b0, ca(0, `PTU_CH_GR0), 32'h0, 4'hf);
    chk("captured gr0 buffered", {16'h0, val | 16'h1}, rd_q & 32'hffff);
    apb(1'b0, ca(0, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("capture clears count", 32'h0, rd_q & 32'hffff);
    $display("test capture done");
    // channel 1: two-phase count, b leads a down through zero, then back up
    apb(1'b1, ca(1, `PTU_CH_MODE), 32'h4, 4'h1);
    apb(1'b1, ca(1, `PTU_CH_IO), 32'h2, 4'h3);
    apb(1'b1, ca(1, `PTU_CH_CNT), 32'h0, 4'hf);
    apb(1'b1, ca(1, `PTU_CH_FLAG), 32'h0, 4'h1);
    apb(1'b1, `PTU_OFF_RUN, 32'h2, 4'h1);
    toggle_pin(4'd9);
    apb(1'b0, ca(1, `PTU_CH_FLAG), 32'h0, 4'hf);
    chk("underflow flag", 32'h20, rd_q & 32'ha0);
    apb(1'b0, ca(1, `PTU_CH_CNT), 32'h0, 4'hf);
    chk("phase down count", 32'hffff, rd_q & 32'hffff);
    chk("ch1 ch2 pins", 32'h1, {24'h0, out2, oe2, out1, oe1});
    toggle_pin(4'd9);
    apb(1'b0, ca(1, `PTU_CH_FLAG), 32'h0, 4'hf);
    chk("phase up wrap", 32'hb0, rd_q & 32'hb0);
    $display("test phase done");
    give_verdict();
  end
endmodule
